// file: arcw_comparator.v
`timescale 1ns/1ns
`include "arcw_defs.vh"
module arcw_comparator (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [31:0] cfg,
  input  wire [3:0]  load_a,
  input  wire [3:0]  load_b,
  input  wire [47:0] res_a,
  input  wire [47:0] res_b,
  output reg         hit
);
  reg  [4:0]  count_q;
  wire [2:0]  sel    = cfg[`ARCW_SEL_HI:`ARCW_SEL_LO];
  wire [1:0]  slot   = sel[1:0];
  wire        grp_b  = sel[`ARCW_GRP_BIT];
  wire [11:0] thr    = cfg[`ARCW_THR_HI:`ARCW_THR_LO];
  wire [11:0] result = grp_b ? res_b[slot*12 +: 12] : res_a[slot*12 +: 12];
  wire        loaded = grp_b ? load_b[slot] : load_a[slot];
  wire        below  = result < thr;
  wire        match  = cfg[`ARCW_COND_BIT] ? !below : below;
  wire [4:0]  limit  = {1'b0, cfg[`ARCW_CNT_HI:`ARCW_CNT_LO]} + 5'h01;
  wire [4:0]  next   = count_q + 5'h01;
  always @(posedge clock) begin
    hit <= 1'b0;
    if (!rst_n) begin
      count_q <= 5'h00;
    end else if (!cfg[`ARCW_EN_BIT]) begin
      count_q <= 5'h00;
    end else if (loaded && match) begin
      if (next >= limit) begin
        hit     <= 1'b1;
        count_q <= 5'h00;
      end else begin
        count_q <= next;
      end
    end
  end
endmodule

// file: arcw_defs.vh
// Behaviour
// - Two comparators; configuration words reset to zero.
// - Threshold in bits 27:16 compared to result.
// - Bits 5:3 pick group A/B slot 0-3.
// - Condition 0 counts result below threshold.
// - Condition 1 counts result at/above threshold.
// - Flag set when counter reaches limit plus one.
// - Compare only when enabled, on each load.
// - Flag with irq enable and its mask bit set raises interrupt request.
// - Reserved configuration bits read zero, no function.
// - Status word flags at bits 7:6, offset b4.
`ifndef ARCW_DEFS_VH
`define ARCW_DEFS_VH
`define ARCW_ADDR_W        8
`define ARCW_OFF_CFG0      8'ha8
`define ARCW_OFF_CFG1      8'hac
`define ARCW_OFF_STATUS    8'hb4
`define ARCW_OFF_MASK      8'hb8
`define ARCW_CFG_RESET     32'h00000000
`define ARCW_CFG_WMASK     32'h0fff0f3f
`define ARCW_THR_HI        27
`define ARCW_THR_LO        16
`define ARCW_CNT_HI        11
`define ARCW_CNT_LO        8
`define ARCW_SEL_HI        5
`define ARCW_SEL_LO        3
`define ARCW_COND_BIT      2
`define ARCW_IE_BIT        1
`define ARCW_EN_BIT        0
`define ARCW_GRP_BIT       2
`define ARCW_ST_FLAG0      6
`define ARCW_ST_FLAG1      7
`define ARCW_ST_DONE_HI    3
`define ARCW_ST_DONE_LO    0
`endif

// file: arcw_seq_model.sv
`timescale 1ns/1ns
module arcw_seq_model (
  input  logic        clock,
  output logic [3:0]  load_a,
  output logic [3:0]  load_b,
  output logic [47:0] res_a,
  output logic [47:0] res_b
);
  initial {load_a, load_b, res_a, res_b} = '0;
  // One result per call, with a single-cycle load pulse on its slot.
  task load(input logic g, input logic [1:0] s, input logic [11:0] v);
    @(posedge clock);
    if (g) res_b[s*12+:12] <= v;
    else res_a[s*12+:12] <= v;
    load_b[s] <= g;
    load_a[s] <= !g;
    @(posedge clock);
    load_a <= 4'h0;
    load_b <= 4'h0;
  endtask
endmodule

// file: arcw_sva.sv
`timescale 1ns/1ns
module arcw_sva (
  input logic        clock,
  input logic        rst_n,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [1:0]  avs_response,
  input logic        irq
);
  logic ans, map, rd;
  assign ans = !avs_waitrequest;
  assign rd = ans && avs_read;
  assign map = avs_address inside {8'ha8, 8'hac, 8'hb4, 8'hb8};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !ans && !irq)
    else $error("busy or irq wrong in reset");
  one_wait_a: assert property ((avs_read || avs_write) && !ans |=> ans)
    else $error("late answer");
  short_answer_a: assert property (ans |=> !ans)
    else $error("answer too long");
  answer_cause_a: assert property (ans |-> $past(avs_read || avs_write))
    else $error("answer without request");
  resp_code_a: assert property (ans |-> avs_response == (map ? 2'b00 : 2'b11))
    else $error("bad response");
  unmapped_zero_a: assert property (rd && !map |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  cfg_reserved_a: assert property (rd && avs_address[7:3] == 5'h15 |->
    (avs_readdata & 32'hf000f0c0) == 32'h0) else $error("reserved bits set");
  status_spare_a: assert property (rd && avs_address == 8'hb4 |->
    avs_readdata[31:8] == 24'h0 && avs_readdata[5:4] == 2'h0) else $error("status spare set");
endmodule
bind arcw_window_compare arcw_sva chk (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .irq(irq));

// file: arcw_window_compare.v
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "arcw_defs.vh"
module arcw_window_compare (
  input  wire                    clock,
  input  wire                    rst_n,
  input  wire [`ARCW_ADDR_W-1:0] avs_address,
  input  wire                    avs_read,
  input  wire                    avs_write,
  input  wire [31:0]             avs_writedata,
  input  wire [3:0]              avs_byteenable,
  output reg  [31:0]             avs_readdata,
  output reg                     avs_waitrequest,
  output reg  [1:0]              avs_response,
  input  wire [3:0]              load_a,
  input  wire [3:0]              load_b,
  input  wire [47:0]             res_a,
  input  wire [47:0]             res_b,
  input  wire [3:0]              conv_done,
  output reg                     irq
);
  reg  [31:0] cfg0_q;
  reg  [31:0] cfg1_q;
  reg  [1:0]  flag_q;
  reg  [1:0]  mask_q;
  reg         ack_q;
  wire        hit0;
  wire        hit1;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        req     = (avs_read || avs_write) && !ack_q;
  // A write lands at the edge where the master sees waitrequest low, never before it.
  wire        wr      = avs_write && ack_q;
  wire [31:0] wdata   = avs_writedata & be_mask;
  wire [1:0]  hits    = {hit1, hit0};
  wire [1:0]  clr     = (wr && avs_address == `ARCW_OFF_STATUS) ?
                        wdata[`ARCW_ST_FLAG1:`ARCW_ST_FLAG0] : 2'h0;
  wire [1:0]  irq_en  = {cfg1_q[`ARCW_IE_BIT], cfg0_q[`ARCW_IE_BIT]};
  wire        irq_d   = |(flag_q & irq_en & mask_q);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] be;
    begin
      merge = ((old & ~be) | (nw & be)) & `ARCW_CFG_WMASK;
    end
  endfunction

  arcw_comparator u_cmp0 (
    .clock  (clock),
    .rst_n  (rst_n),
    .cfg    (cfg0_q),
    .load_a (load_a),
    .load_b (load_b),
    .res_a  (res_a),
    .res_b  (res_b),
    .hit    (hit0)
  );

  arcw_comparator u_cmp1 (
    .clock  (clock),
    .rst_n  (rst_n),
    .cfg    (cfg1_q),
    .load_a (load_a),
    .load_b (load_b),
    .res_a  (res_a),
    .res_b  (res_b),
    .hit    (hit1)
  );

  // One wait cycle per access keeps readdata a plain flop.
  always @(posedge clock) begin
    if (!rst_n) begin
      cfg0_q          <= `ARCW_CFG_RESET;
      cfg1_q          <= `ARCW_CFG_RESET;
      flag_q          <= 2'h0;
      mask_q          <= 2'h0;
      ack_q           <= 1'b0;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      avs_response    <= 2'h0;
      irq             <= 1'b0;
    end else begin
      ack_q           <= req;
      avs_waitrequest <= !req;
      irq             <= irq_d;
      // A hit in the same cycle as a clear keeps the flag set.
      flag_q <= (flag_q & ~clr) | hits;
      if (wr && avs_address == `ARCW_OFF_CFG0) begin
        cfg0_q <= merge(cfg0_q, avs_writedata, be_mask);
      end
      if (wr && avs_address == `ARCW_OFF_CFG1) begin
        cfg1_q <= merge(cfg1_q, avs_writedata, be_mask);
      end
      if (wr && avs_address == `ARCW_OFF_MASK) begin
        mask_q <= wdata[1:0];
      end
      if (req) begin
        avs_readdata <= 32'h00000000;
        avs_response <= 2'h0;
        case (avs_address)
          `ARCW_OFF_CFG0: avs_readdata <= cfg0_q;
          `ARCW_OFF_CFG1: avs_readdata <= cfg1_q;
          `ARCW_OFF_STATUS: begin
            avs_readdata[`ARCW_ST_FLAG1:`ARCW_ST_FLAG0]     <= flag_q;
            avs_readdata[`ARCW_ST_DONE_HI:`ARCW_ST_DONE_LO] <= conv_done;
          end
          `ARCW_OFF_MASK: avs_readdata[1:0] <= mask_q;
          default: avs_response <= 2'h3;
        endcase
      end
    end
  end
endmodule

// file: arcw_window_compare_tb.sv
`timescale 1ns/1ns
module arcw_window_compare_tb;
  logic        clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, irq, avs_waitrequest;
  logic [7:0]  avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0]  avs_response;
  logic [3:0]  load_a, load_b;
  logic [47:0] res_a, res_b;
  int          miscompares = 0, num_checks = 0;
  always #5 clock = ~clock;
  arcw_window_compare dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .load_a(load_a), .load_b(load_b), .res_a(res_a),
    .res_b(res_b), .conv_done(4'h9), .irq(irq));
  arcw_seq_model seq (.clock(clock), .load_a(load_a), .load_b(load_b), .res_a(res_a),
    .res_b(res_b));
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // A read compares against d; a write stores d.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, d);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task t_regs;
    bus(0, 8'ha8, 32'h0);
    bus(0, 8'hac, 32'h0);
    bus(1, 8'hac, 32'hffffffff);
    bus(0, 8'hac, 32'h0fff0f3f);
    bus(0, 8'h40, 32'h0);
    bus(0, 8'hb4, 32'h00000009);
  endtask
  task t_less;
    bus(1, 8'hb8, 32'h3);
    bus(1, 8'ha8, 32'h0100012b);
    seq.load(1, 1, 12'h0ff);
    seq.load(0, 1, 12'h000);
    seq.load(1, 1, 12'h100);
    repeat (4) @(posedge clock);
    chk(irq, 1'b0);
    seq.load(1, 1, 12'h0ff);
    repeat (4) @(posedge clock);
    chk(irq, 1'b1);
    bus(0, 8'hb4, 32'h00000049);
    bus(1, 8'hb4, 32'h40);
    seq.load(1, 1, 12'h000);
    repeat (4) @(posedge clock);
    bus(0, 8'hb4, 32'h00000009);
    chk(irq, 1'b0);
  endtask
  task t_geq;
    bus(1, 8'ha8, 32'h0100002a);
    seq.load(1, 1, 12'h000);
    seq.load(1, 1, 12'h000);
    bus(1, 8'hac, 32'h01000015);
    seq.load(0, 2, 12'h100);
    repeat (4) @(posedge clock);
    bus(0, 8'hb4, 32'h00000089);
    chk(irq, 1'b0);
  endtask
  task results;
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs;
    t_less;
    t_geq;
    results;
  end
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    results;
  end
endmodule
